// *** hdl/regulator_output_control_regs.svh ***
// Purpose: offsets, reset values, field positions and timing of the
//          regulator output control bank
// Assumes: 25 MHz clock, byte-wide register port
// Notes:   definitions only
// Overview of operation
// - step-down enable bit 7, off at reset
// - range bit writable only when off or disabling
// - range selects 0.60-1.30 or 1.30-2.10 V
// - step-down code 0.60 V plus 50 mV steps
// - discharge when disabled unless bit set
// - peak limit offset -50/0/+50/+100 mA
// - linear enable bit 7, active 20 ms later
// - linear voltage code locked while enabled
// - first linear: 25 mV then 50 mV steps
// - others: 50 mV then 75 mV steps
// - limit bypass bits 6:4, locked while enabled
// - switch select bits 2:0, locked while enabled
`ifndef REGULATOR_OUTPUT_CONTROL_REGS_SVH
`define REGULATOR_OUTPUT_CONTROL_REGS_SVH

`define REG_STEP_DOWN_CONTROL 8'h30
`define REG_STEP_DOWN_CONFIG 8'h31
`define REG_LINREG0_CONTROL 8'h32
`define REG_LINREG1_CONTROL 8'h33
`define REG_LINREG2_CONTROL 8'h34
`define REG_LINREG_OPTIONS 8'h35
`define REG_STEP_DOWN_RAMP 8'h50

`define RST_STEP_DOWN_CONTROL 8'h5c
`define RST_STEP_DOWN_CONFIG 8'h00
`define RST_LINREG0_CONTROL 8'h24
`define RST_LINREG1_CONTROL 8'h28
`define RST_LINREG2_CONTROL 8'h14
`define RST_LINREG_OPTIONS 8'h00
`define RST_STEP_DOWN_RAMP 8'h1b
`define RAMP_RESERVED_READ 8'h18

`define ENABLE_BIT 7
`define RANGE_BIT 6
`define DISCHARGE_BIT 5
`define SD_CODE_MSB 4
`define PEAK_MSB 1
`define LIN_CODE_MSB 5
`define BYPASS_LSB 4
`define SWITCH_LSB 0
`define RAMP_MSB 1

`define SD_LOW_TOP 5'h0e
`define SD_HIGH_BOTTOM 5'h0e
`define SD_CODE_TOP 5'h1e
`define LIN_KNEE 6'h20
`define LIN12_CODE_TOP 6'h2c

`define SD_BASE_MV 12'h258
`define STEP_25_MV 12'h019
`define STEP_50_MV 12'h032
`define STEP_75_MV 12'h04b
`define LIN_BASE_MV 12'h320
`define LIN0_KNEE_MV 12'h640
`define LIN12_KNEE_MV 12'h960

`define CLK_HZ 25000000
`define LINREG_DELAY_MS 20
`define RAMP_SLOW_MS 4
`define RAMP_MID_MS 2
`define RAMP_FAST_MS 1
`define RAMP_OFF 2'h0
`define RAMP_FAST 2'h1
`define RAMP_MID 2'h2

`endif

// *** hdl/regulator_output_control_pkg.sv ***
// Purpose: carrier types of the regulator output control bank
// Assumes: nothing
// Notes:   used as regulator_output_control_pkg::name
package regulator_output_control_pkg;

  typedef struct packed {
    logic enable;
    logic discharge;
    logic range_high;
    logic [4:0] code;
    logic [1:0] peak_limit_offset;
    logic [11:0] millivolt;
  } step_down_out_type;

  typedef struct packed {
    logic active;
    logic [5:0] code;
    logic limit_bypass;
    logic switch_select;
    logic [11:0] millivolt;
  } linreg_out_type;

endpackage

// *** hdl/activation_delay.sv ***
// Purpose: holds an output off for a fixed count after its enable rises
// Assumes: enable synchronous to clk
// Notes:   dropping enable restarts the count
`timescale 1ns/1ps
module activation_delay #(
  parameter int DELAY_CYC = 500000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  output logic active
);
  localparam int CNT_W = $clog2(DELAY_CYC + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(DELAY_CYC - 1);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic active_nxt;

  assign active_nxt = enable && (active || cnt_r == LAST);
  assign cnt_nxt = (enable && !active) ? cnt_r + CNT_W'(1) : '0;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
      active <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      active <= active_nxt;
    end
  end
endmodule

// *** hdl/regulator_output_control_regs.sv ***
// Purpose: control register bank for one step-down and three linear outputs
// Assumes: byte register port synchronous to clk, serial front end outside
// Notes:   read data appear one cycle after reg_rd
`timescale 1ns/1ps
`include "regulator_output_control_regs.svh"
module regulator_output_control_regs #(
  parameter int LINREG_DELAY_CYC = `LINREG_DELAY_MS * (`CLK_HZ / 1000),
  parameter int RAMP_FAST_CYC = `RAMP_FAST_MS * (`CLK_HZ / 1000),
  parameter int RAMP_MID_CYC = `RAMP_MID_MS * (`CLK_HZ / 1000),
  parameter int RAMP_SLOW_CYC = `RAMP_SLOW_MS * (`CLK_HZ / 1000)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output regulator_output_control_pkg::step_down_out_type step_down_out,
  output regulator_output_control_pkg::linreg_out_type [2:0] linreg_out
);
  localparam int RAMP_W = $clog2(RAMP_SLOW_CYC + 1);

  // clamps into the selected range; a stray code cannot overshoot
  function automatic logic [4:0] sd_clamp(input logic [4:0] code,
                                          input logic high);
    logic [4:0] c;
    c = code;
    if (high) begin
      if (c < `SD_HIGH_BOTTOM)
        c = `SD_HIGH_BOTTOM;
      if (c > `SD_CODE_TOP)
        c = `SD_CODE_TOP;
    end else if (c > `SD_LOW_TOP) begin
      c = `SD_LOW_TOP;
    end
    return c;
  endfunction

  function automatic logic [11:0] sd_mv(input logic [4:0] code);
    return `SD_BASE_MV + 12'(code) * `STEP_50_MV;
  endfunction

  // reserved codes of outputs 1 and 2 are held at the top setting
  function automatic logic [11:0] lin_mv(input logic [5:0] code,
                                         input logic first);
    logic [5:0] c;
    logic [11:0] mv;
    c = (!first && code > `LIN12_CODE_TOP) ? `LIN12_CODE_TOP : code;
    if (c <= `LIN_KNEE)
      mv = `LIN_BASE_MV + 12'(c) * (first ? `STEP_25_MV : `STEP_50_MV);
    else if (first)
      mv = `LIN0_KNEE_MV + 12'(c - `LIN_KNEE) * `STEP_50_MV;
    else
      mv = `LIN12_KNEE_MV + 12'(c - `LIN_KNEE) * `STEP_75_MV;
    return mv;
  endfunction

  function automatic logic [7:0] lin_addr(input int idx);
    return `REG_LINREG0_CONTROL + 8'(idx);
  endfunction

  logic sd_en_r;
  logic sd_range_r;
  logic [4:0] sd_code_r;
  logic sd_nodisch_r;
  logic [1:0] sd_peak_r;
  logic [1:0] ramp_r;
  logic [4:0] applied_r;
  logic [RAMP_W-1:0] ramp_cnt_r;
  logic [2:0] lin_en_r;
  logic [2:0][5:0] lin_code_r;
  logic [2:0] bypass_r;
  logic [2:0] switch_r;
  logic [2:0][11:0] lin_mv_r;
  logic [2:0] lin_active;
  logic [11:0] sd_mv_r;

  logic sd_en_nxt;
  logic sd_range_nxt;
  logic [4:0] sd_code_nxt;
  logic sd_nodisch_nxt;
  logic [1:0] sd_peak_nxt;
  logic [1:0] ramp_nxt;
  logic [4:0] applied_nxt;
  logic [RAMP_W-1:0] ramp_cnt_nxt;
  logic [2:0] lin_en_nxt;
  logic [2:0][5:0] lin_code_nxt;
  logic [2:0] bypass_nxt;
  logic [2:0] switch_nxt;
  logic [2:0][11:0] lin_mv_nxt;
  logic [7:0] rdata_nxt;
  regulator_output_control_pkg::step_down_out_type sd_out_nxt;

  wire wr_sd_ctrl = reg_wr && reg_addr == `REG_STEP_DOWN_CONTROL;
  wire wr_sd_cfg = reg_wr && reg_addr == `REG_STEP_DOWN_CONFIG;
  wire wr_opt = reg_wr && reg_addr == `REG_LINREG_OPTIONS;
  wire wr_ramp = reg_wr && reg_addr == `REG_STEP_DOWN_RAMP;
  wire [2:0] wr_lin;

  // step-down control
  wire range_open = !sd_en_r || !reg_wdata[`ENABLE_BIT];
  assign sd_en_nxt = wr_sd_ctrl ? reg_wdata[`ENABLE_BIT] : sd_en_r;
  assign sd_range_nxt = (wr_sd_ctrl && range_open) ?
    reg_wdata[`RANGE_BIT] : sd_range_r;
  assign sd_code_nxt = wr_sd_ctrl ?
    reg_wdata[`SD_CODE_MSB:0] : sd_code_r;
  assign sd_nodisch_nxt = wr_sd_cfg ?
    reg_wdata[`DISCHARGE_BIT] : sd_nodisch_r;
  assign sd_peak_nxt = wr_sd_cfg ? reg_wdata[`PEAK_MSB:0] : sd_peak_r;
  assign ramp_nxt = wr_ramp ? reg_wdata[`RAMP_MSB:0] : ramp_r;

  // ramp toward the clamped target, one code per period
  wire [4:0] target = sd_clamp(sd_code_r, sd_range_r);
  wire [RAMP_W-1:0] ramp_last =
    ramp_r == `RAMP_FAST ? RAMP_W'(RAMP_FAST_CYC - 1) :
    ramp_r == `RAMP_MID ? RAMP_W'(RAMP_MID_CYC - 1) :
    RAMP_W'(RAMP_SLOW_CYC - 1);
  wire jump = !sd_en_r || ramp_r == `RAMP_OFF;
  wire at_target = applied_r == target;
  wire ramp_tick = ramp_cnt_r == ramp_last;
  assign ramp_cnt_nxt = (jump || at_target || ramp_tick) ?
    '0 : ramp_cnt_r + RAMP_W'(1);
  assign applied_nxt = jump ? target :
    (at_target || !ramp_tick) ? applied_r :
    (applied_r < target) ? applied_r + 5'(1) :
    applied_r - 5'(1);

  assign sd_out_nxt.enable = sd_en_nxt;
  assign sd_out_nxt.discharge = !sd_en_nxt && !sd_nodisch_nxt;
  assign sd_out_nxt.range_high = sd_range_nxt;
  assign sd_out_nxt.code = applied_nxt;
  assign sd_out_nxt.peak_limit_offset = sd_peak_nxt;
  assign sd_out_nxt.millivolt = sd_mv(applied_nxt);

  // linear outputs: code, bypass and switch fields locked while their enable is held
  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_lin
      assign wr_lin[i] = reg_wr && reg_addr == lin_addr(i);
      assign lin_en_nxt[i] = wr_lin[i] ?
        reg_wdata[`ENABLE_BIT] : lin_en_r[i];
      assign lin_code_nxt[i] = (wr_lin[i] && !lin_en_r[i]) ?
        reg_wdata[`LIN_CODE_MSB:0] : lin_code_r[i];
      assign bypass_nxt[i] = (wr_opt && !lin_en_r[i]) ?
        reg_wdata[`BYPASS_LSB + i] : bypass_r[i];
      assign switch_nxt[i] = (wr_opt && !lin_en_r[i]) ?
        reg_wdata[`SWITCH_LSB + i] : switch_r[i];
      assign lin_mv_nxt[i] = lin_mv(lin_code_nxt[i], i == 0);
      assign linreg_out[i] = '{lin_active[i], lin_code_r[i], bypass_r[i],
                               switch_r[i], lin_mv_r[i]};

      activation_delay #(
        .DELAY_CYC(LINREG_DELAY_CYC)
      ) u_delay (
        .clk(clk),
        .rst(rst),
        .enable(lin_en_r[i]),
        .active(lin_active[i])
      );
    end
  endgenerate

  // reserved bits read zero, except the ramp register's fixed pattern
  wire [2:0][7:0] lin_read;
  assign lin_read[0] = {lin_en_r[0], 1'b0, lin_code_r[0]};
  assign lin_read[1] = {lin_en_r[1], 1'b0, lin_code_r[1]};
  assign lin_read[2] = {lin_en_r[2], 1'b0, lin_code_r[2]};
  assign rdata_nxt = !reg_rd ? reg_rdata :
    reg_addr == `REG_STEP_DOWN_CONTROL ?
      {sd_en_r, sd_range_r, 1'b0, sd_code_r} :
    reg_addr == `REG_STEP_DOWN_CONFIG ?
      {2'h0, sd_nodisch_r, 3'h0, sd_peak_r} :
    reg_addr == `REG_LINREG0_CONTROL ? lin_read[0] :
    reg_addr == `REG_LINREG1_CONTROL ? lin_read[1] :
    reg_addr == `REG_LINREG2_CONTROL ? lin_read[2] :
    reg_addr == `REG_LINREG_OPTIONS ?
      {1'b0, bypass_r, 1'b0, switch_r} :
    reg_addr == `REG_STEP_DOWN_RAMP ?
      (`RAMP_RESERVED_READ | {6'h00, ramp_r}) :
    8'h00;

  localparam logic [7:0] SD_RST = `RST_STEP_DOWN_CONTROL;
  localparam logic [7:0] CFG_RST = `RST_STEP_DOWN_CONFIG;
  localparam logic [7:0] OPT_RST = `RST_LINREG_OPTIONS;
  localparam logic [7:0] RAMP_RST = `RST_STEP_DOWN_RAMP;
  localparam logic [5:0] L0_RST = 6'(`RST_LINREG0_CONTROL);
  localparam logic [5:0] L1_RST = 6'(`RST_LINREG1_CONTROL);
  localparam logic [5:0] L2_RST = 6'(`RST_LINREG2_CONTROL);

  always_ff @(posedge clk) begin
    if (rst) begin
      sd_en_r <= SD_RST[`ENABLE_BIT];
      sd_range_r <= SD_RST[`RANGE_BIT];
      sd_code_r <= SD_RST[`SD_CODE_MSB:0];
      sd_nodisch_r <= CFG_RST[`DISCHARGE_BIT];
      sd_peak_r <= CFG_RST[`PEAK_MSB:0];
      ramp_r <= RAMP_RST[`RAMP_MSB:0];
      applied_r <= SD_RST[`SD_CODE_MSB:0];
      ramp_cnt_r <= '0;
      lin_en_r <= 3'h0;
      lin_code_r <= {L2_RST, L1_RST, L0_RST};
      bypass_r <= OPT_RST[`BYPASS_LSB +: 3];
      switch_r <= OPT_RST[`SWITCH_LSB +: 3];
      lin_mv_r <= {lin_mv(L2_RST, 1'b0), lin_mv(L1_RST, 1'b0),
                   lin_mv(L0_RST, 1'b1)};
      step_down_out <= '{1'b0, 1'b1, SD_RST[`RANGE_BIT],
                         SD_RST[`SD_CODE_MSB:0], CFG_RST[`PEAK_MSB:0],
                         sd_mv(SD_RST[`SD_CODE_MSB:0])};
      reg_rdata <= 8'h00;
    end else begin
      sd_en_r <= sd_en_nxt;
      sd_range_r <= sd_range_nxt;
      sd_code_r <= sd_code_nxt;
      sd_nodisch_r <= sd_nodisch_nxt;
      sd_peak_r <= sd_peak_nxt;
      ramp_r <= ramp_nxt;
      applied_r <= applied_nxt;
      ramp_cnt_r <= ramp_cnt_nxt;
      lin_en_r <= lin_en_nxt;
      lin_code_r <= lin_code_nxt;
      bypass_r <= bypass_nxt;
      switch_r <= switch_nxt;
      lin_mv_r <= lin_mv_nxt;
      step_down_out <= sd_out_nxt;
      reg_rdata <= rdata_nxt;
    end
  end
endmodule

// *** tb/regulator_output_control_assertions.sv ***
// Purpose: port checks of the regulator control bank
// Assumes: bound to the top module, one clock domain
// Notes: en0_r mirrors the first linear enable for lock checks
`timescale 1ns/1ps
module regulator_output_control_checker #(
  parameter int LINREG_DELAY_CYC = 20
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire regulator_output_control_pkg::step_down_out_type step_down_out,
  input wire regulator_output_control_pkg::linreg_out_type [2:0] linreg_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic en0_r;
  wire sd_wr = reg_wr && reg_addr == 8'h30;
  wire l0_wr = reg_wr && reg_addr == 8'h32;
  wire [5:0] c0 = linreg_out[0].code;
  wire [5:0] c1 = linreg_out[1].code;
  int on_cnt_r;
  always_ff @(posedge clk)
    if (rst)
      en0_r <= 1'b0;
    else if (l0_wr)
      en0_r <= reg_wdata[7];
  // cycles spent enabled but not yet active
  always_ff @(posedge clk)
    if (rst || !en0_r)
      on_cnt_r <= 0;
    else if (!linreg_out[0].active)
      on_cnt_r <= on_cnt_r + 1;
  enable_load_a: assert property (sd_wr |=>
    step_down_out.enable == $past(reg_wdata[7])) else $error("enable load");
  range_lock_a: assert property (sd_wr && step_down_out.enable &&
    reg_wdata[7] |=> $stable(step_down_out.range_high)) else $error("range");
  sd_mv_a: assert property (step_down_out.millivolt == 12'h258 +
    12'h032 * {7'h00, step_down_out.code}) else $error("step mv");
  discharge_a: assert property (reg_wr && reg_addr == 8'h31 |=>
    (step_down_out.enable ||
    step_down_out.discharge == !$past(reg_wdata[5]))) else $error("dis");
  lin_delay_a: assert property (!en0_r && l0_wr && reg_wdata[7] |=>
    !linreg_out[0].active [*8]) else $error("early active");
  lin_time_a: assert property ($rose(linreg_out[0].active) |->
    on_cnt_r == LINREG_DELAY_CYC) else $error("active delay");
  lin_lock_a: assert property (en0_r && l0_wr && reg_wdata[7] |=>
    $stable(c0) [*2]) else $error("code lock");
  lin0_mv_a: assert property (linreg_out[0].millivolt == (c0 <= 6'h20 ?
    12'h320 + 12'h019 * c0 : 12'h640 + 12'h032 * (c0 - 6'h20)))
    else $error("lin0 mv");
  lin1_mv_a: assert property (linreg_out[1].millivolt == (c1 <= 6'h20 ?
    12'h320 + 12'h032 * c1 : c1 <= 6'h2c ?
    12'h960 + 12'h04b * (c1 - 6'h20) : 12'hce4)) else $error("lin1 mv");
  opt_lock_a: assert property (en0_r && reg_wr && reg_addr == 8'h35 |=>
    $stable({linreg_out[0].limit_bypass, linreg_out[0].switch_select}) [*2])
    else $error("opt lock");
  ramp_read_a: assert property (reg_rd && reg_addr == 8'h50 |=>
    reg_rdata[7:2] == 6'h06) else $error("ramp read");
  cover property (sd_wr && step_down_out.enable && reg_wdata[7]);
  cover property ($rose(linreg_out[0].active));
  cover property (en0_r && reg_wr && reg_addr == 8'h35);
endmodule
bind regulator_output_control_regs regulator_output_control_checker #(
  .LINREG_DELAY_CYC(LINREG_DELAY_CYC)) i_chk (.clk(clk), .rst(rst),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .step_down_out(step_down_out), .linreg_out(linreg_out));

// *** tb/regulator_output_control_regs_tb_top.sv ***
// Purpose: self-checking bench of the regulator control bank
// Assumes: short delay and ramp counts
// Notes: random linear codes kept in the documented range
`timescale 1ns/1ps
module regulator_output_control_regs_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  regulator_output_control_pkg::step_down_out_type sd;
  regulator_output_control_pkg::linreg_out_type [2:0] lo;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [7:0] adr_tab [7] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h50};
  logic [7:0] rst_tab [7] = '{8'h5c, 8'h00, 8'h24, 8'h28, 8'h14, 8'h00, 8'h1b};
  logic [5:0] corner [3] = '{6'h3f, 6'h2c, 6'h20};
  always #20 clk = ~clk;
  regulator_output_control_regs #(.LINREG_DELAY_CYC(20), .RAMP_FAST_CYC(4),
    .RAMP_MID_CYC(8), .RAMP_SLOW_CYC(16)) i_dut (.clk(clk), .rst(rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .step_down_out(sd),
    .linreg_out(lo));
  task automatic test_done;
    if (err_total == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    chk({16'h0000, reg_rdata}, {16'h0000, e});
  endtask
  // wide codes switch to a coarser step above the knee
  function automatic logic [11:0] lin_mv(input int i, input logic [5:0] c);
    if (c <= 6'h20)
      return 12'h320 + (i == 0 ? 12'h019 : 12'h032) * c;
    return (i == 0 ? 12'h640 : 12'h960) +
      (i == 0 ? 12'h032 : 12'h04b) * (c - 6'h20);
  endfunction
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      test_done;
    end
  end
  initial begin
    logic [5:0] c;
    logic [7:0] o;
    int i;
    int t;
    void'($urandom(32'hc11025e7));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(sd, {3'b011, 5'h1c, 2'h0, 12'h7d0});
    for (int k = 0; k < 7; k++) begin
      rd(adr_tab[k], rst_tab[k]);
    end
    rd(8'h36, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(8'h31, 8'(k));
      chk({22'h0, sd.peak_limit_offset}, 24'(k));
    end
    wr(8'h31, 8'h20);
    @(posedge clk);
    chk({23'h0, sd.discharge}, 24'h0);
    wr(8'h31, 8'h00);
    wr(8'h50, 8'h00);
    wr(8'h30, 8'hd4);
    wr(8'h30, 8'h95);
    rd(8'h30, 8'hd5);
    chk({18'h0, sd.enable, sd.code}, {18'h0, 1'b1, 5'h15});
    wr(8'h30, 8'h08);
    rd(8'h30, 8'h08);
    chk({sd.range_high, sd.code, sd.millivolt}, {1'b0, 5'h08, 12'h3e8});
    wr(8'h30, 8'h4e);
    wr(8'h50, 8'h01);
    rd(8'h50, 8'h19);
    wr(8'h30, 8'hd0);
    chk({23'h0, sd.code == 5'h10}, 24'h0);
    repeat (5) @(posedge clk);
    chk({19'h0, sd.code}, 24'h0f);
    repeat (11) @(posedge clk);
    chk({19'h0, sd.code}, 24'h10);
    wr(8'h30, 8'h50);
    // middle rate: one step per eight cycles
    wr(8'h50, 8'h02);
    wr(8'h30, 8'hd1);
    repeat (5) @(posedge clk);
    chk({19'h0, sd.code}, 24'h10);
    repeat (4) @(posedge clk);
    chk({19'h0, sd.code}, 24'h11);
    for (int k = 0; k < 12; k++) begin
      i = k % 3;
      c = k < 3 ? corner[k] : 6'($urandom_range(i == 0 ? 63 : 44));
      wr(8'h32 + 8'(i), {2'b00, c});
      @(posedge clk);
      chk({6'h0, lo[i].code, lo[i].millivolt}, {6'h0, c, lin_mv(i, c)});
    end
    wr(8'h33, 8'h3f);
    chk({12'h0, lo[1].millivolt}, 24'hce4);
    wr(8'h32, 8'h10);
    wr(8'h32, 8'h90);
    t = 0;
    while (lo[0].active !== 1'b1 && t < 60) begin
      @(posedge clk);
      t++;
    end
    chk(24'(t), 24'h14);
    wr(8'h32, 8'ha5);
    rd(8'h32, 8'h90);
    o = (8'($urandom) & 8'h77) | 8'h11;
    wr(8'h35, o);
    rd(8'h35, o & 8'h66);
    wr(8'h32, 8'h25);
    rd(8'h32, 8'h10);
    wr(8'h35, o);
    rd(8'h35, o);
    chk({18'h0, lo[2].limit_bypass, lo[1].limit_bypass,
      lo[0].limit_bypass, lo[2].switch_select, lo[1].switch_select,
      lo[0].switch_select}, {18'h0, o[6:4], o[2:0]});
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h35, 8'h00);
    rd(8'h30, 8'h5c);
    test_done;
  end
endmodule
